/* hw/pfc_flow_cfg.v */
// Port 2 flow-control configuration and status register, AHB-Lite slave.
// Assumes straps stay stable across reset release, and that negotiation
// results and duplex come from the port in the hclk domain.
//
// Functional notes
// - bit 6 turns half-duplex backpressure on
// - bit 5 reads resolved duplex, 1 half
// - bit 4 reads pause receive active
// - bit 3 reads pause transmit active
// - bit 2 manual pause receive enable
// - bit 1 manual pause transmit enable
// - select 0, negotiation on: negotiated result in full duplex
// - select 0, negotiation off: manual bits in full duplex
// - select 1: manual bits in full duplex
// - reads show the settings in force
// - writes never touch PHY advertisement
// - writable defaults come from reset straps
// - EEPROM reload updates the strap fields
// - status defaults combine several straps
`timescale 1ns/100ps
`default_nettype none
`include "pfc_regs.vh"
module pfc_flow_cfg #(
	parameter ADDR_W = `PFC_ADDR_W
) (
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [ADDR_W-1:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg hreadyout_ff,
	output reg hresp_ff,
	output reg [31:0] hrdata_ff,
	// Configuration straps
	input wire backpressure_default_strap,
	input wire pause_default_strap,
	input wire manual_select_default_strap,
	input wire duplex_half_default_strap,
	input wire autoneg_default_strap,
	// EEPROM loader rewrite of the strap values
	input wire eeprom_strap_load,
	input wire eeprom_backpressure_strap,
	input wire eeprom_pause_strap,
	input wire eeprom_manual_select_strap,
	input wire eeprom_duplex_half_strap,
	input wire eeprom_autoneg_strap,
	// Live port state
	input wire link_up,
	input wire autoneg_enable,
	input wire port_duplex_half,
	input wire an_pause_transmit,
	input wire an_pause_receive,
	// Settings in force, to the port MAC
	output reg backpressure_active_ff,
	output reg pause_transmit_active_ff,
	output reg pause_receive_active_ff,
	output reg duplex_half_active_ff
);

	// Strap capture after reset release
	reg strap_taken_ff;
	wire strap_load;
	reg src_bp;
	reg src_pause;
	reg src_manual;
	reg src_dup;
	reg src_an;

	// Bus data-phase state
	reg wr_pend_ff;
	wire addr_phase;
	wire reg_hit;
	wire wr_now;

	// Address decode parts
	wire addr_match;
	wire size_word;

	// Write data fields
	wire wr_bp_val;
	wire wr_rx_val;
	wire wr_tx_val;
	wire wr_manual_val;

	// Register fields
	wire backpressure_enable;
	wire manual_pause_select;
	wire [1:0] pause_en_q;
	wire pause_transmit_enable;
	wire pause_receive_enable;

	// Status bits
	reg resolved_duplex_status_ff;
	reg active_pause_receive_status_ff;
	reg active_pause_transmit_status_ff;
	reg nxt_dup;
	reg nxt_rx;
	reg nxt_tx;
	wire live_tx;
	wire live_rx;
	wire init_tx;
	wire init_rx;

	// Read path
	reg [6:0] rd_fields;
	reg [31:0] nxt_hrdata;

	// straps taken once
	// Straps must be steady across release; taken at the first edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_taken_ff <= `PFC_RST_BIT;
		end else begin
			strap_taken_ff <= 1'h1;
		end
	end

	// EEPROM values
	// Pins feed the first capture only; later loads take the loader's copy
	assign strap_load = !strap_taken_ff || eeprom_strap_load;

	always @* begin
		if (strap_taken_ff) begin
			src_bp = eeprom_backpressure_strap;
			src_pause = eeprom_pause_strap;
			src_manual = eeprom_manual_select_strap;
			src_dup = eeprom_duplex_half_strap;
			src_an = eeprom_autoneg_strap;
		end else begin
			src_bp = backpressure_default_strap;
			src_pause = pause_default_strap;
			src_manual = manual_select_default_strap;
			src_dup = duplex_half_default_strap;
			src_an = autoneg_default_strap;
		end
	end

	// Address phase decode
	assign addr_phase = hsel && hready && (htrans == `PFC_HTRANS_NONSEQ);
	assign addr_match = (haddr == `PFC_FLOW_CFG_OFFSET);
	assign size_word = (hsize == `PFC_HSIZE_WORD);
	assign reg_hit = addr_match && size_word;

	// Write held over into its data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= `PFC_RST_BIT;
		end else begin
			wr_pend_ff <= addr_phase && hwrite && reg_hit;
		end
	end

	// No wait states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= `PFC_RST_BIT;
		end else begin
			hreadyout_ff <= 1'h1;
		end
	end

	// Every transfer, mapped or not, ends OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_ff <= `PFC_HRESP_OKAY;
		end else begin
			hresp_ff <= `PFC_HRESP_OKAY;
		end
	end

	// only writable bits kept
	// Bits 5..3 are status and take no write
	assign wr_now = wr_pend_ff;
	assign wr_bp_val = hwdata[`PFC_BIT_BP_EN];
	assign wr_rx_val = hwdata[`PFC_BIT_RX_EN];
	assign wr_tx_val = hwdata[`PFC_BIT_TX_EN];
	assign wr_manual_val = hwdata[`PFC_BIT_MANUAL_SEL];

	pfc_strap_field #(
		.W(1)
	) u_bp_field (
		.clk(hclk),
		.rst_n(hresetn),
		.load(strap_load),
		.load_val(src_bp),
		.wr(wr_now),
		.wr_val(wr_bp_val),
		.q_ff(backpressure_enable)
	);

	pfc_strap_field #(
		.W(2)
	) u_pause_field (
		.clk(hclk),
		.rst_n(hresetn),
		.load(strap_load),
		.load_val({src_pause, src_pause}),
		.wr(wr_now),
		.wr_val({wr_rx_val, wr_tx_val}),
		.q_ff(pause_en_q)
	);

	assign pause_receive_enable = pause_en_q[1];
	assign pause_transmit_enable = pause_en_q[0];

	pfc_strap_field #(
		.W(1)
	) u_manual_field (
		.clk(hclk),
		.rst_n(hresetn),
		.load(strap_load),
		.load_val(src_manual),
		.wr(wr_now),
		.wr_val(wr_manual_val),
		.q_ff(manual_pause_select)
	);

	pfc_fc_resolve u_live_resolve (
		.manual_sel(manual_pause_select),
		.an_enable(autoneg_enable),
		.duplex_half(port_duplex_half),
		.man_tx(pause_transmit_enable),
		.man_rx(pause_receive_enable),
		.an_tx(an_pause_transmit),
		.an_rx(an_pause_receive),
		.tx_on(live_tx),
		.rx_on(live_rx)
	);

	// status from strap mix
	// One pause strap feeds both paths, so they cannot disagree
	pfc_fc_resolve u_init_resolve (
		.manual_sel(src_manual),
		.an_enable(src_an),
		.duplex_half(src_dup),
		.man_tx(src_pause),
		.man_rx(src_pause),
		.an_tx(src_pause),
		.an_rx(src_pause),
		.tx_on(init_tx),
		.rx_on(init_rx)
	);

	// A reload restarts the status from the new straps
	// Strap-derived status holds until the link reports
	always @* begin
		nxt_dup = resolved_duplex_status_ff;
		nxt_rx = active_pause_receive_status_ff;
		nxt_tx = active_pause_transmit_status_ff;
		if (strap_load) begin
			nxt_dup = src_dup;
			nxt_rx = init_rx;
			nxt_tx = init_tx;
		end else if (link_up) begin
			nxt_dup = port_duplex_half;
			nxt_rx = live_rx;
			nxt_tx = live_tx;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resolved_duplex_status_ff <= `PFC_RST_BIT;
			active_pause_receive_status_ff <= `PFC_RST_BIT;
			active_pause_transmit_status_ff <= `PFC_RST_BIT;
		end else begin
			resolved_duplex_status_ff <= nxt_dup;
			active_pause_receive_status_ff <= nxt_rx;
			active_pause_transmit_status_ff <= nxt_tx;
		end
	end

	// backpressure in force, one cycle after the field
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			backpressure_active_ff <= `PFC_RST_BIT;
		end else begin
			backpressure_active_ff <= backpressure_enable;
		end
	end

	// pause and duplex in force mirror the status bits
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pause_transmit_active_ff <= `PFC_RST_BIT;
			pause_receive_active_ff <= `PFC_RST_BIT;
			duplex_half_active_ff <= `PFC_RST_BIT;
		end else begin
			pause_transmit_active_ff <= nxt_tx;
			pause_receive_active_ff <= nxt_rx;
			duplex_half_active_ff <= nxt_dup;
		end
	end

	// read back, forwarding a write in its data phase
	// A read right behind a write sees the new fields, or the old ones if a strap load lands in that cycle
	always @* begin
		rd_fields = 7'h00;
		rd_fields[`PFC_BIT_BP_EN] = backpressure_enable;
		rd_fields[`PFC_BIT_CUR_DUP] = resolved_duplex_status_ff;
		rd_fields[`PFC_BIT_CUR_RX] = active_pause_receive_status_ff;
		rd_fields[`PFC_BIT_CUR_TX] = active_pause_transmit_status_ff;
		rd_fields[`PFC_BIT_RX_EN] = pause_receive_enable;
		rd_fields[`PFC_BIT_TX_EN] = pause_transmit_enable;
		rd_fields[`PFC_BIT_MANUAL_SEL] = manual_pause_select;
		if (wr_now && !strap_load) begin
			rd_fields[`PFC_BIT_BP_EN] = wr_bp_val;
			rd_fields[`PFC_BIT_RX_EN] = wr_rx_val;
			rd_fields[`PFC_BIT_TX_EN] = wr_tx_val;
			rd_fields[`PFC_BIT_MANUAL_SEL] = wr_manual_val;
		end
	end

	always @* begin
		nxt_hrdata = hrdata_ff;
		if (addr_phase && !hwrite) begin
			nxt_hrdata = reg_hit ? {{`PFC_RSVD_W{1'h0}}, rd_fields} : `PFC_RST_WORD;
		end
	end

	// Read data stands until the next read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= `PFC_RST_WORD;
		end else begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	// no path to the PHY advertisement
	// The block has no port toward the PHY's advertisement register,
	// so software writes here cannot change advertised pause ability.

endmodule
`default_nettype wire

/* hw/pfc_regs.vh */
// Register map, field positions, reset values and bus codes for the
// port 2 flow-control configuration block. Definitions only.
`ifndef PFC_REGS_VH
`define PFC_REGS_VH

// Byte offset of the port 2 flow-control register
`define PFC_FLOW_CFG_OFFSET 12'h1a4
`define PFC_ADDR_W 12

// Field positions
`define PFC_BIT_MANUAL_SEL 0
`define PFC_BIT_TX_EN 1
`define PFC_BIT_RX_EN 2
`define PFC_BIT_CUR_TX 3
`define PFC_BIT_CUR_RX 4
`define PFC_BIT_CUR_DUP 5
`define PFC_BIT_BP_EN 6
`define PFC_RSVD_W 25

// Values held while reset is asserted, before the straps are taken
`define PFC_RST_BIT 1'h0
`define PFC_RST_WORD 32'h0000_0000

// Bus codes
`define PFC_HTRANS_NONSEQ 2'h2
`define PFC_HSIZE_WORD 3'h2
`define PFC_HRESP_OKAY 1'h0

`endif

/* hw/pfc_strap_field.v */
// Register field loaded from a strap source or by a software write.
// Assumes load and wr are one-cycle strobes in the hclk domain.
`timescale 1ns/100ps
`default_nettype none
module pfc_strap_field #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_n,
	input wire load,
	input wire [W-1:0] load_val,
	input wire wr,
	input wire [W-1:0] wr_val,
	output reg [W-1:0] q_ff
);

	// Strap reload has priority over a same-cycle write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= {W{1'h0}};
		end else if (load) begin
			q_ff <= load_val;
		end else if (wr) begin
			q_ff <= wr_val;
		end
	end

endmodule
`default_nettype wire

/* hw/pfc_fc_resolve.v */
// Combinational resolution of the pause enables in force on a port.
// Assumes all inputs are stable levels in one clock domain.
`timescale 1ns/100ps
`default_nettype none
module pfc_fc_resolve (
	input wire manual_sel,
	input wire an_enable,
	input wire duplex_half,
	input wire man_tx,
	input wire man_rx,
	input wire an_tx,
	input wire an_rx,
	output reg tx_on,
	output reg rx_on
);

	always @* begin
		tx_on = 1'h0;
		rx_on = 1'h0;
		if (!duplex_half) begin
			if (manual_sel || !an_enable) begin
				tx_on = man_tx;
				rx_on = man_rx;
			end else begin
				tx_on = an_tx;
				rx_on = an_rx;
			end
		end
	end

endmodule
`default_nettype wire

/* testbench/pfc_flow_cfg_chk.sv */
// Checker for the port 2 flow-control register outputs.
// Bound onto pfc_flow_cfg; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module pfc_flow_cfg_chk (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout_ff,
	input wire hresp_ff,
	input wire link_up,
	input wire port_duplex_half,
	input wire eeprom_strap_load,
	input wire eeprom_backpressure_strap,
	input wire eeprom_pause_strap,
	input wire eeprom_duplex_half_strap,
	input wire backpressure_active_ff,
	input wire pause_transmit_active_ff,
	input wire pause_receive_active_ff,
	input wire duplex_half_active_ff
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property ($past(hresetn) |-> hreadyout_ff) else $error("ready low");
	a_resp_okay: assert property (hresp_ff == 1'h0) else $error("response not okay");
	a_dup_track: assert property ($past(hresetn) && link_up && !eeprom_strap_load
		|=> duplex_half_active_ff == $past(port_duplex_half)) else $error("duplex not tracked");
	a_half_nopause: assert property ($past(hresetn) && link_up && port_duplex_half && !eeprom_strap_load
		|=> !pause_transmit_active_ff && !pause_receive_active_ff) else $error("pause in half duplex");
	a_status_hold: assert property ($past(hresetn) && !link_up && !eeprom_strap_load
		|=> $stable({pause_transmit_active_ff, pause_receive_active_ff, duplex_half_active_ff}))
		else $error("status moved without link");
	a_load_dup: assert property (eeprom_strap_load
		|=> duplex_half_active_ff == $past(eeprom_duplex_half_strap)) else $error("loaded duplex wrong");
	a_load_pause: assert property (eeprom_strap_load && !eeprom_duplex_half_strap
		|=> pause_transmit_active_ff == $past(eeprom_pause_strap)
		&& pause_receive_active_ff == $past(eeprom_pause_strap)) else $error("loaded pause wrong");
	a_load_half: assert property (eeprom_strap_load && eeprom_duplex_half_strap
		|=> !pause_transmit_active_ff && !pause_receive_active_ff) else $error("loaded half pause");
	a_load_bp: assert property (eeprom_strap_load
		|=> ##1 backpressure_active_ff == $past(eeprom_backpressure_strap, 2)) else $error("loaded bp wrong");
endmodule
`default_nettype wire

/* testbench/tb_pfc_flow_cfg.sv */
// Self-checking bench for the port 2 flow-control register.
// Assumes pfc_flow_cfg with hready fed back from hreadyout_ff.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_regs.vh"
module tb_pfc_flow_cfg;
	localparam [11:0] REG_A = `PFC_FLOW_CFG_OFFSET;
	reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0, eeprom_strap_load = 1'h0;
	reg [11:0] haddr = 12'h0;
	reg [1:0] htrans = 2'h0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] hwdata = 32'h0, rd, exp;
	// Order {autoneg, duplex, manual, pause, backpressure}
	reg [4:0] strap = 5'h13, eep = 5'h0;
	reg link_up = 1'h0, autoneg_enable = 1'h0, port_duplex_half = 1'h0;
	reg an_pause_transmit = 1'h0, an_pause_receive = 1'h0;
	wire hready, hresp_ff, bp_act, tx_act, rx_act, dup_act;
	wire [31:0] hrdata_ff;
	integer num_errors = 0, compares = 0, i, n;
	pfc_flow_cfg dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
		.hreadyout_ff(hready), .hresp_ff, .hrdata_ff, .backpressure_default_strap(strap[0]),
		.pause_default_strap(strap[1]), .manual_select_default_strap(strap[2]),
		.duplex_half_default_strap(strap[3]), .autoneg_default_strap(strap[4]), .eeprom_strap_load,
		.eeprom_backpressure_strap(eep[0]), .eeprom_pause_strap(eep[1]), .eeprom_manual_select_strap(eep[2]),
		.eeprom_duplex_half_strap(eep[3]), .eeprom_autoneg_strap(eep[4]), .link_up, .autoneg_enable,
		.port_duplex_half, .an_pause_transmit, .an_pause_receive, .backpressure_active_ff(bp_act),
		.pause_transmit_active_ff(tx_act), .pause_receive_active_ff(rx_act), .duplex_half_active_ff(dup_act));
	initial forever #10 hclk = ~hclk;
	task check(input [31:0] got, input [31:0] want);
		begin
			compares = compares + 1;
			if (got !== want) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, want);
			end
		end
	endtask
	task test_done;
		begin
			$display("errors %0d compares %0d", num_errors, compares);
			if (num_errors == 0 && compares > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task wait_rdy;
		begin
			n = 0;
			@(posedge hclk);
			while (hready !== 1'h1 && n < 20) begin
				n = n + 1;
				@(posedge hclk);
			end
			if (hready !== 1'h1) begin
				num_errors = num_errors + 1;
				test_done;
			end
		end
	endtask
	task xfer(input [11:0] a, input w, input [2:0] sz, input [31:0] wd);
		begin
			haddr <= a;
			hwrite <= w;
			hsize <= sz;
			htrans <= 2'h2;
			wait_rdy;
			htrans <= 2'h0;
			hwdata <= wd;
			wait_rdy;
			rd = hrdata_ff;
		end
	endtask
	task rd_chk(input [11:0] a, input [31:0] want);
		begin
			xfer(a, 1'h0, 3'h2, 32'h0);
			check(rd, want);
		end
	endtask
	task eload(input [4:0] v, input [31:0] want);
		begin
			eep <= v;
			@(posedge hclk);
			eeprom_strap_load <= 1'h1;
			@(posedge hclk);
			eeprom_strap_load <= 1'h0;
			@(posedge hclk);
			rd_chk(REG_A, want);
		end
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd_chk(REG_A, 32'h5e);
		xfer(REG_A, 1'h1, 3'h2, 32'hffffffff);
		@(posedge hclk);
		rd_chk(REG_A, 32'h5f);
		check(bp_act, 32'h1);
		xfer(12'h1a0, 1'h1, 3'h2, 32'h0);
		rd_chk(12'h1a0, 32'h0);
		xfer(REG_A, 1'h1, 3'h1, 32'h0);
		rd_chk(REG_A, 32'h5f);
		hsel <= 1'h0;
		xfer(REG_A, 1'h1, 3'h2, 32'h0);
		hsel <= 1'h1;
		rd_chk(REG_A, 32'h5f);
		link_up <= 1'h1;
		for (i = 0; i < 32; i = i + 1) begin
			autoneg_enable <= i[1];
			port_duplex_half <= i[2];
			an_pause_transmit <= i[3];
			an_pause_receive <= i[4];
			exp = {25'h0, i[0] ^ i[2], i[2], !i[2] && (i[0] || !i[1] ? !i[4] : i[4]),
				!i[2] && (i[0] || !i[1] ? !i[3] : i[3]), !i[4], !i[3], i[0] == 1};
			xfer(REG_A, 1'h1, 3'h2, exp | 32'hffffff38);
			repeat (2) @(posedge hclk);
			rd_chk(REG_A, exp);
			check({dup_act, rx_act, tx_act}, exp[5:3]);
			check(bp_act, exp[6]);
		end
		link_up <= 1'h0;
		eload(5'h0e, 32'h27);
		eload(5'h11, 32'h40);
		hresetn <= 1'h0;
		strap <= 5'h0c;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd_chk(REG_A, 32'h21);
		test_done;
	end
endmodule
bind pfc_flow_cfg pfc_flow_cfg_chk chk (.hclk, .hresetn, .hreadyout_ff, .hresp_ff, .link_up, .port_duplex_half,
	.eeprom_strap_load, .eeprom_backpressure_strap, .eeprom_pause_strap, .eeprom_duplex_half_strap,
	.backpressure_active_ff, .pause_transmit_active_ff, .pause_receive_active_ff, .duplex_half_active_ff);
`default_nettype wire
